// *** core/thdc_codec.sv ***
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module thdc_codec (
  input  wire logic                    CLK_SYS_IN,
  input  wire logic                    ARST_N_IN,
  input  wire logic                    PSEL_IN,
  input  wire logic                    PENABLE_IN,
  input  wire logic                    PWRITE_IN,
  input  wire logic [11:0]             PADDR_IN,
  input  wire logic [31:0]             PWDATA_IN,
  output logic [31:0]                  PRDATA_OUT,
  output logic                         PREADY_OUT,
  output logic                         PSLVERR_OUT,
  input  wire logic                    C_VALID_IN,
  input  wire thdc_pkg::thdc_cin_type  C_PKT_IN,
  output logic                         C_READY_OUT,
  output logic                         C_VALID_OUT,
  output thdc_pkg::thdc_cout_type      C_PKT_OUT,
  input  wire logic                    C_OUT_READY_IN,
  input  wire logic                    D_VALID_IN,
  input  wire thdc_pkg::thdc_din_type  D_PKT_IN,
  output logic                         D_READY_OUT,
  output logic                         D_VALID_OUT,
  output thdc_pkg::thdc_dout_type      D_PKT_OUT,
  input  wire logic                    D_OUT_READY_IN,
  output logic                         D_DROP_OUT,
  output logic                         D_DISCARD_OUT
);

  // ===================================================================
  // Helpers
  function automatic logic [15:0] pay_len(input thdc_pkg::thdc_hdr_type h);
    pay_len = h.tot_len - {10'h000, h.ver_ihl_tos[11:8], 2'b00}
                        - {10'h000, h.tcp_off, 2'b00};
  endfunction

  function automatic logic [15:0] hdr_len(input thdc_pkg::thdc_hdr_type h);
    hdr_len = {10'h000, h.ver_ihl_tos[11:8], 2'b00} + {10'h000, h.tcp_off, 2'b00};
  endfunction

  function automatic logic [4:0] enc_len(input logic [15:0] v);
    enc_len = (v != 16'h0000 && v[15:8] == 8'h00) ? 5'h01 : 5'h03;
  endfunction

  function automatic thdc_pkg::thdc_cbuf_type enc_put(input thdc_pkg::thdc_cbuf_type b,
                                                      input logic [4:0] i,
                                                      input logic [15:0] v);
    thdc_pkg::thdc_cbuf_type r;
    r = b;
    if (v != 16'h0000 && v[15:8] == 8'h00) begin
      r[i] = v[7:0];
    end else begin
      r[i]         = 8'h00;
      r[i + 5'h01] = v[15:8];
      r[i + 5'h02] = v[7:0];
    end
    enc_put = r;
  endfunction

  function automatic logic [15:0] dec_val(input thdc_pkg::thdc_cbuf_type b,
                                          input logic [4:0] i);
    if (b[i] == 8'h00) begin
      dec_val = {b[i + 5'h01], b[i + 5'h02]};
    end else begin
      dec_val = {8'h00, b[i]};
    end
  endfunction

  function automatic logic [4:0] dec_len(input thdc_pkg::thdc_cbuf_type b,
                                         input logic [4:0] i);
    dec_len = (b[i] == 8'h00) ? 5'h03 : 5'h01;
  endfunction

  function automatic logic [15:0] ip_csum(input thdc_pkg::thdc_hdr_type h);
    logic [31:0] s;
    s = {16'h0000, h.ver_ihl_tos} + {16'h0000, h.tot_len} + {16'h0000, h.ip_id}
      + {16'h0000, h.frag} + {16'h0000, h.ttl, h.proto}
      + {16'h0000, h.src[31:16]} + {16'h0000, h.src[15:0]}
      + {16'h0000, h.dst[31:16]} + {16'h0000, h.dst[15:0]};
    s = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
    s = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
    ip_csum = ~s[15:0];
  endfunction

  // ===================================================================
  // State
  thdc_pkg::thdc_hdr_type comp_slots [0:thdc_pkg::SLOT_COUNT-1];
  thdc_pkg::thdc_hdr_type decomp_slots [0:thdc_pkg::SLOT_COUNT-1];
  logic [1:0]             ctrl;
  logic [7:0]             last_sent;
  logic [7:0]             last_recv;
  logic                   discard;
  logic [15:0]            cnt_comp;
  logic [15:0]            cnt_drop;
  logic                   c_fire;
  logic                   d_fire;

  // ===================================================================
  // APB slave
  logic        apb_setup;
  logic        apb_access;
  logic        apb_hit;
  logic [31:0] apb_rd;

  assign apb_setup  = PSEL_IN & ~PENABLE_IN;
  assign apb_access = PSEL_IN & PENABLE_IN;
  assign PREADY_OUT = apb_access;

  always_comb begin
    apb_hit = 1'b1;
    apb_rd  = 32'h0000_0000;
    case (PADDR_IN)
      thdc_pkg::REG_CTRL:   apb_rd = {30'h0000_0000, ctrl};
      thdc_pkg::REG_STATUS: apb_rd = {8'h00, last_recv, last_sent, 7'h00, discard};
      thdc_pkg::REG_COUNT:  apb_rd = {cnt_drop, cnt_comp};
      default:              apb_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PRDATA_OUT  <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else if (apb_setup) begin
      PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : apb_rd;
      PSLVERR_OUT <= ~apb_hit;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl <= thdc_pkg::CTRL_RESET;
    end else if (apb_access && PWRITE_IN && PADDR_IN == thdc_pkg::REG_CTRL) begin
      ctrl <= PWDATA_IN[1:0];
    end
  end

  // ===================================================================
  // Compressor decision and header build
  thdc_pkg::thdc_hdr_type c_cur;
  thdc_pkg::thdc_hdr_type c_old;
  logic [15:0]            c_prev_pay;
  logic [15:0]            d_win;
  logic [31:0]            d_ack;
  logic [31:0]            d_seq;
  logic [15:0]            d_id;
  logic                   c_raw;
  logic [3:0]             c_low;
  logic [3:0]             c_emit;
  logic [7:0]             c_mask;
  logic [4:0]             c_n;
  thdc_pkg::thdc_cbuf_type c_buf;
  thdc_pkg::thdc_cout_type next_cout;

  assign c_cur = C_PKT_IN.hdr;
  assign c_old = comp_slots[C_PKT_IN.slot[thdc_pkg::SLOT_BITS-1:0]];

  always_comb begin
    c_prev_pay = pay_len(c_old);
    d_win      = c_cur.win - c_old.win;
    d_ack      = c_cur.ack - c_old.ack;
    d_seq      = c_cur.seq - c_old.seq;
    d_id       = c_cur.ip_id - c_old.ip_id;
    c_raw      = C_PKT_IN.raw;
    c_low      = 4'h0;
    if (c_cur.tcp_flags[thdc_pkg::TCP_URG_BIT]) begin
      c_low = c_low | thdc_pkg::MASK_URG;
    end else if (c_cur.urp != c_old.urp) begin
      c_raw = 1'b1;
    end
    if (d_win != 16'h0000) begin
      c_low = c_low | thdc_pkg::MASK_WIN;
    end
    if (d_ack[31:16] != 16'h0000) begin
      c_raw = 1'b1;
    end else if (d_ack != 32'h0000_0000) begin
      c_low = c_low | thdc_pkg::MASK_ACK;
    end
    if (d_seq[31:16] != 16'h0000) begin
      c_raw = 1'b1;
    end else if (d_seq != 32'h0000_0000) begin
      c_low = c_low | thdc_pkg::MASK_SEQ;
    end
    c_emit = c_low;
    if ((c_low & thdc_pkg::ECHO_SPECIAL_MASK) == thdc_pkg::ECHO_SPECIAL_MASK) begin
      c_raw = 1'b1;
    end else if (c_low == thdc_pkg::MASK_SEQ && d_seq[15:0] == c_prev_pay) begin
      c_low  = thdc_pkg::UNIDIRECTIONAL_SPECIAL_MASK;
      c_emit = 4'h0;
    end else if (c_low == (thdc_pkg::MASK_SEQ | thdc_pkg::MASK_ACK) && d_seq == d_ack
                 && d_seq[15:0] == c_prev_pay) begin
      c_low  = thdc_pkg::ECHO_SPECIAL_MASK;
      c_emit = 4'h0;
    end else if (c_low == 4'h0 && (pay_len(c_cur) == 16'h0000
                                   || c_prev_pay != 16'h0000)) begin
      c_raw = 1'b1;
    end
    c_mask = {4'h0, c_low};
    if (C_PKT_IN.slot != last_sent) begin
      c_mask = c_mask | thdc_pkg::MASK_CONN;
    end
    if (d_id != 16'h0001) begin
      c_mask = c_mask | thdc_pkg::MASK_ID;
    end
    if (c_cur.tcp_flags[thdc_pkg::TCP_PSH_BIT]) begin
      c_mask = c_mask | thdc_pkg::MASK_PUSH;
    end
    c_buf    = '0;
    c_buf[0] = c_mask;
    c_n      = 5'h01;
    if ((c_mask & thdc_pkg::MASK_CONN) != 8'h00) begin
      c_buf[c_n] = C_PKT_IN.slot;
      c_n        = c_n + 5'h01;
    end
    c_buf[c_n]         = c_cur.tcp_sum[15:8];
    c_buf[c_n + 5'h01] = c_cur.tcp_sum[7:0];
    c_n                = c_n + 5'h02;
    if ((c_emit & thdc_pkg::MASK_URG) != 4'h0) begin
      c_buf = enc_put(c_buf, c_n, c_cur.urp);
      c_n   = c_n + enc_len(c_cur.urp);
    end
    if ((c_emit & thdc_pkg::MASK_WIN) != 4'h0) begin
      c_buf = enc_put(c_buf, c_n, d_win);
      c_n   = c_n + enc_len(d_win);
    end
    if ((c_emit & thdc_pkg::MASK_ACK) != 4'h0) begin
      c_buf = enc_put(c_buf, c_n, d_ack[15:0]);
      c_n   = c_n + enc_len(d_ack[15:0]);
    end
    if ((c_emit & thdc_pkg::MASK_SEQ) != 4'h0) begin
      c_buf = enc_put(c_buf, c_n, d_seq[15:0]);
      c_n   = c_n + enc_len(d_seq[15:0]);
    end
    if ((c_mask & thdc_pkg::MASK_ID) != 8'h00) begin
      c_buf = enc_put(c_buf, c_n, d_id);
      c_n   = c_n + enc_len(d_id);
    end
    next_cout.slot  = C_PKT_IN.slot;
    next_cout.bytes = c_buf;
    next_cout.len   = c_n;
    if (C_PKT_IN.plain) begin
      next_cout.kind = thdc_pkg::PACKET_PLAIN_IP;
      next_cout.len  = 5'h00;
    end else if (c_raw) begin
      next_cout.kind = thdc_pkg::PACKET_A;
      next_cout.len  = 5'h00;
    end else begin
      next_cout.kind = thdc_pkg::PACKET_B;
    end
  end

  assign C_READY_OUT = ctrl[0] & (~C_VALID_OUT | C_OUT_READY_IN);
  assign c_fire      = C_VALID_IN & C_READY_OUT;

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      C_VALID_OUT <= 1'b0;
      C_PKT_OUT   <= '0;
      last_sent   <= thdc_pkg::CONN_RESET;
      cnt_comp    <= 16'h0000;
    end else if (c_fire) begin
      C_VALID_OUT <= 1'b1;
      C_PKT_OUT   <= next_cout;
      if (!C_PKT_IN.plain) begin
        last_sent <= C_PKT_IN.slot;
      end
      if (next_cout.kind == thdc_pkg::PACKET_B) begin
        cnt_comp <= cnt_comp + 16'h0001;
      end
    end else if (C_OUT_READY_IN) begin
      C_VALID_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (c_fire && !C_PKT_IN.plain) begin
      comp_slots[C_PKT_IN.slot[thdc_pkg::SLOT_BITS-1:0]] <= c_cur;
    end
  end

  // ===================================================================
  // Decompressor
  thdc_pkg::thdc_cbuf_type d_buf;
  thdc_pkg::thdc_hdr_type  d_h;
  logic [7:0]              d_mask;
  logic [7:0]              d_slot;
  logic [4:0]              d_i;
  logic [15:0]             d_prev;
  logic [15:0]             d_v;
  logic                    d_out;
  logic                    d_save;
  logic                    d_set_disc;
  logic                    d_clr_disc;
  logic                    d_pass;

  assign d_buf = D_PKT_IN.bytes;

  always_comb begin
    d_mask     = d_buf[0];
    d_slot     = last_recv;
    d_i        = 5'h01;
    d_h        = D_PKT_IN.hdr;
    d_prev     = 16'h0000;
    d_v        = 16'h0000;
    d_out      = 1'b0;
    d_save     = 1'b0;
    d_set_disc = 1'b0;
    d_clr_disc = 1'b0;
    d_pass     = 1'b0;
    case (D_PKT_IN.kind)
      thdc_pkg::PACKET_PLAIN_IP: begin
        d_out  = 1'b1;
        d_pass = 1'b1;
        d_i    = 5'h00;
      end
      thdc_pkg::PACKET_A: begin
        d_i    = 5'h00;
        d_slot = D_PKT_IN.hdr.proto;
        if ({1'b0, d_slot} >= thdc_pkg::SLOT_COUNT) begin
          d_set_disc = 1'b1;
        end else begin
          d_clr_disc = 1'b1;
          d_h.proto  = thdc_pkg::TCP_PROTO;
          d_save     = 1'b1;
          d_out      = 1'b1;
        end
      end
      thdc_pkg::PACKET_B: begin
        if ((d_mask & thdc_pkg::MASK_CONN) != 8'h00) begin
          d_slot = d_buf[1];
          d_i    = 5'h02;
          if ({1'b0, d_slot} >= thdc_pkg::SLOT_COUNT) begin
            d_set_disc = 1'b1;
          end else begin
            d_clr_disc = 1'b1;
            d_out      = 1'b1;
          end
        end else begin
          d_out = ~discard;
        end
        d_h         = decomp_slots[d_slot[thdc_pkg::SLOT_BITS-1:0]];
        d_h.tcp_sum = {d_buf[d_i], d_buf[d_i + 5'h01]};
        d_i         = d_i + 5'h02;
        d_h.tcp_flags[thdc_pkg::TCP_PSH_BIT] = (d_mask & thdc_pkg::MASK_PUSH) != 8'h00;
        d_prev      = pay_len(d_h);
        if (d_mask[3:0] == thdc_pkg::UNIDIRECTIONAL_SPECIAL_MASK) begin
          d_h.seq = d_h.seq + {16'h0000, d_prev};
        end else if (d_mask[3:0] == thdc_pkg::ECHO_SPECIAL_MASK) begin
          d_h.seq = d_h.seq + {16'h0000, d_prev};
          d_h.ack = d_h.ack + {16'h0000, d_prev};
        end else begin
          d_h.tcp_flags[thdc_pkg::TCP_URG_BIT] = (d_mask[3:0] & thdc_pkg::MASK_URG) != 4'h0;
          if ((d_mask[3:0] & thdc_pkg::MASK_URG) != 4'h0) begin
            d_h.urp = dec_val(d_buf, d_i);
            d_i     = d_i + dec_len(d_buf, d_i);
          end
          if ((d_mask[3:0] & thdc_pkg::MASK_WIN) != 4'h0) begin
            d_h.win = d_h.win + dec_val(d_buf, d_i);
            d_i     = d_i + dec_len(d_buf, d_i);
          end
          if ((d_mask[3:0] & thdc_pkg::MASK_ACK) != 4'h0) begin
            d_h.ack = d_h.ack + {16'h0000, dec_val(d_buf, d_i)};
            d_i     = d_i + dec_len(d_buf, d_i);
          end
          if ((d_mask[3:0] & thdc_pkg::MASK_SEQ) != 4'h0) begin
            d_h.seq = d_h.seq + {16'h0000, dec_val(d_buf, d_i)};
            d_i     = d_i + dec_len(d_buf, d_i);
          end
        end
        if ((d_mask & thdc_pkg::MASK_ID) != 8'h00) begin
          d_v       = dec_val(d_buf, d_i);
          d_h.ip_id = d_h.ip_id + d_v;
          d_i       = d_i + dec_len(d_buf, d_i);
        end else begin
          d_h.ip_id = d_h.ip_id + 16'h0001;
        end
        d_h.tot_len = D_PKT_IN.len - {11'h000, d_i} + hdr_len(d_h);
        d_h.ip_sum  = ip_csum(d_h);
        d_save      = d_out;
      end
      default: begin
        d_set_disc = 1'b1;
        d_i        = 5'h00;
      end
    endcase
  end

  assign D_READY_OUT   = ctrl[1] & (~D_VALID_OUT | D_OUT_READY_IN);
  assign d_fire        = D_VALID_IN & D_READY_OUT;
  assign D_DISCARD_OUT = discard;

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      discard   <= 1'b0;
      last_recv <= thdc_pkg::CONN_RESET;
    end else if (d_fire) begin
      if (d_set_disc) begin
        discard <= 1'b1;
      end else if (d_clr_disc) begin
        discard   <= 1'b0;
        last_recv <= d_slot;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      D_VALID_OUT <= 1'b0;
      D_PKT_OUT   <= '0;
      D_DROP_OUT  <= 1'b0;
      cnt_drop    <= 16'h0000;
    end else begin
      D_DROP_OUT <= d_fire & ~d_out;
      if (d_fire && d_out) begin
        D_VALID_OUT       <= 1'b1;
        D_PKT_OUT.pass    <= d_pass;
        D_PKT_OUT.pay_off <= d_i;
        D_PKT_OUT.hdr     <= d_h;
      end else if (D_OUT_READY_IN) begin
        D_VALID_OUT <= 1'b0;
      end
      if (d_fire && !d_out) begin
        cnt_drop <= cnt_drop + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (d_fire && d_save) begin
      decomp_slots[d_slot[thdc_pkg::SLOT_BITS-1:0]] <= d_h;
    end
  end

endmodule

`default_nettype wire

// *** inc/thdc_pkg.sv ***
`default_nettype none
package thdc_pkg;

  // =====================================================================
  // Connection slots and buffers
  localparam int unsigned  SLOT_BITS  = 4;
  localparam logic [8:0]   SLOT_COUNT = 9'h010;
  localparam int unsigned  HDR_BYTES  = 20;

  // =====================================================================
  // Link packet types
  localparam logic [2:0] PACKET_ERROR    = 3'h0;
  localparam logic [2:0] PACKET_PLAIN_IP = 3'h1;
  localparam logic [2:0] PACKET_A        = 3'h2;
  localparam logic [2:0] PACKET_B        = 3'h3;

  // =====================================================================
  // Change mask bits and special masks (low nibble)
  localparam logic [7:0] MASK_CONN = 8'h40;
  localparam logic [7:0] MASK_ID   = 8'h20;
  localparam logic [7:0] MASK_PUSH = 8'h10;
  localparam logic [3:0] MASK_SEQ  = 4'h8;
  localparam logic [3:0] MASK_ACK  = 4'h4;
  localparam logic [3:0] MASK_WIN  = 4'h2;
  localparam logic [3:0] MASK_URG  = 4'h1;
  localparam logic [3:0] UNIDIRECTIONAL_SPECIAL_MASK = 4'hf;
  localparam logic [3:0] ECHO_SPECIAL_MASK           = 4'hb;

  // =====================================================================
  // Header constants
  localparam logic [7:0] TCP_PROTO   = 8'h06;
  localparam int unsigned TCP_URG_BIT = 5;
  localparam int unsigned TCP_PSH_BIT = 3;

  // =====================================================================
  // APB register map
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_COUNT  = 12'h008;
  localparam logic [1:0]  CTRL_RESET = 2'h3;
  localparam logic [7:0]  CONN_RESET = 8'h00;

  // =====================================================================
  // Carriers
  typedef logic [HDR_BYTES-1:0][7:0] thdc_cbuf_type;

  typedef struct packed {
    logic [15:0] ver_ihl_tos;
    logic [15:0] tot_len;
    logic [15:0] ip_id;
    logic [15:0] frag;
    logic [7:0]  ttl;
    logic [7:0]  proto;
    logic [15:0] ip_sum;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] seq;
    logic [31:0] ack;
    logic [3:0]  tcp_off;
    logic [7:0]  tcp_flags;
    logic [15:0] win;
    logic [15:0] tcp_sum;
    logic [15:0] urp;
  } thdc_hdr_type;

  typedef struct packed {
    logic         plain;
    logic         raw;
    logic [7:0]   slot;
    thdc_hdr_type hdr;
  } thdc_cin_type;

  typedef struct packed {
    logic [2:0]    kind;
    logic [7:0]    slot;
    logic [4:0]    len;
    thdc_cbuf_type bytes;
  } thdc_cout_type;

  typedef struct packed {
    logic [2:0]    kind;
    logic [15:0]   len;
    thdc_cbuf_type bytes;
    thdc_hdr_type  hdr;
  } thdc_din_type;

  typedef struct packed {
    logic         pass;
    logic [4:0]   pay_off;
    thdc_hdr_type hdr;
  } thdc_dout_type;

endpackage
`default_nettype wire

// *** sim/thdc_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module thdc_checker (
  input wire logic                    CLK_SYS_IN,
  input wire logic                    ARST_N_IN,
  input wire logic                    C_VALID_IN,
  input wire thdc_pkg::thdc_cin_type  C_PKT_IN,
  input wire logic                    C_READY_OUT,
  input wire logic                    C_VALID_OUT,
  input wire thdc_pkg::thdc_cout_type C_PKT_OUT,
  input wire logic                    D_VALID_IN,
  input wire thdc_pkg::thdc_din_type  D_PKT_IN,
  input wire logic                    D_READY_OUT,
  input wire logic                    D_VALID_OUT,
  input wire thdc_pkg::thdc_dout_type D_PKT_OUT,
  input wire logic                    D_DROP_OUT,
  input wire logic                    D_DISCARD_OUT
);
  logic ca;
  logic da;
  assign ca = C_VALID_IN && C_READY_OUT;
  assign da = D_VALID_IN && D_READY_OUT;
  // =========
  // Handshake and header checks
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);
  c_answer_a: assert property (ca |=> C_VALID_OUT)
    else $error("no compressor answer");
  push_copy_a: assert property (ca && C_PKT_IN.hdr.tcp_flags[3] |=>
      C_PKT_OUT.kind != thdc_pkg::PACKET_B || C_PKT_OUT.bytes[0][4])
    else $error("push copy lost");
  plain_pass_a: assert property (da && D_PKT_IN.kind == thdc_pkg::PACKET_PLAIN_IP |=>
      D_VALID_OUT && D_PKT_OUT.pass && D_PKT_OUT.hdr == $past(D_PKT_IN.hdr)
      && $stable(D_DISCARD_OUT))
    else $error("plain packet altered");
  err_toss_a: assert property (da && (D_PKT_IN.kind == 3'h0 || D_PKT_IN.kind[2]) |=>
      D_DROP_OUT && D_DISCARD_OUT && !D_VALID_OUT)
    else $error("error packet not tossed");
  toss_drop_a: assert property (da && D_PKT_IN.kind == thdc_pkg::PACKET_B
      && !D_PKT_IN.bytes[0][6] && D_DISCARD_OUT |=> D_DROP_OUT && !D_VALID_OUT)
    else $error("packet passed while tossing");
  bad_slot_a: assert property (da && D_PKT_IN.kind == thdc_pkg::PACKET_A
      && {1'b0, D_PKT_IN.hdr.proto} >= thdc_pkg::SLOT_COUNT |=> D_DROP_OUT && D_DISCARD_OUT)
    else $error("bad slot accepted");
  proto_fix_a: assert property (da && D_PKT_IN.kind == thdc_pkg::PACKET_A
      && {1'b0, D_PKT_IN.hdr.proto} < thdc_pkg::SLOT_COUNT |=> D_VALID_OUT
      && D_PKT_OUT.hdr.proto == thdc_pkg::TCP_PROTO && !D_DISCARD_OUT)
    else $error("protocol not restored");
  drop_cause_a: assert property (D_DROP_OUT |-> $past(da) && !D_VALID_OUT)
    else $error("drop without request");
endmodule
`default_nettype wire

// *** sim/thdc_sink.sv ***
`timescale 1ns/1ns
`default_nettype none
module thdc_sink (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic slow_in,
  output logic      c_ready_out,
  output logic      d_ready_out
);
  logic [1:0] cnt;
  // =========
  // Link side stalls when slow: compressor output three cycles in four, decompressor output every other cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  assign c_ready_out = !slow_in || cnt == 2'h3;
  assign d_ready_out = !slow_in || cnt[0];
endmodule
`default_nettype wire

// *** sim/thdc_codec_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module thdc_codec_tb;
  logic clk, rst_n, psel, pen, pwr, pry, perr, err, cv, cor, crdy, cvo, dv, dor, drdy, dvo;
  logic ddrop, ddisc, slow;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd;
  thdc_pkg::thdc_cin_type  ci;
  thdc_pkg::thdc_cout_type co;
  thdc_pkg::thdc_din_type  di;
  thdc_pkg::thdc_dout_type dq;
  thdc_pkg::thdc_hdr_type  h, hb, e;
  int num_errors = 0, cmp_count = 0, cyc = 0, drops = 0;
  thdc_codec u_thdc_codec (
    .CLK_SYS_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(pry), .PSLVERR_OUT(perr), .C_VALID_IN(cv), .C_PKT_IN(ci),
    .C_READY_OUT(crdy), .C_VALID_OUT(cvo), .C_PKT_OUT(co), .C_OUT_READY_IN(cor),
    .D_VALID_IN(dv), .D_PKT_IN(di), .D_READY_OUT(drdy), .D_VALID_OUT(dvo),
    .D_PKT_OUT(dq), .D_OUT_READY_IN(dor), .D_DROP_OUT(ddrop), .D_DISCARD_OUT(ddisc));
  thdc_sink u_thdc_sink (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
    .c_ready_out(cor), .d_ready_out(dor));
  // =========
  // Tasks
  task automatic chk(input logic [319:0] s, input logic [319:0] x);
    cmp_count++;
    if (s !== x) begin
      num_errors++;
      $display("wrong value at %0t: %h vs %h", $time, s, x);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (!pry);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] ipsum(input thdc_pkg::thdc_hdr_type x);
    logic [159:0] w;
    logic [31:0] s;
    x.ip_sum = 16'h0;
    w = x[283:124];
    s = 32'h0;
    for (int i = 0; i < 10; i++) s += w[16*i +: 16];
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    return ~s[15:0];
  endfunction
  task automatic cstep(input logic r, input logic [7:0] s, input logic [2:0] k, input int n,
                       input logic [95:0] l);
    ci <= {k == thdc_pkg::PACKET_PLAIN_IP, r, s, h};
    cv <= 1'b1;
    do @(posedge clk); while (!crdy);
    cv <= 1'b0;
    do @(posedge clk); while (!cvo);
    chk(co.kind, k);
    if (k == thdc_pkg::PACKET_A) chk(co.slot, s);
    else chk(co.len, n);
    for (int i = 0; i < n; i++) chk(co.bytes[i], l[8*(n-1-i) +: 8]);
  endtask
  task automatic dstep(input logic [2:0] k, input int n, input int p, input logic [95:0] l,
                       input logic d);
    thdc_pkg::thdc_cbuf_type b;
    b = '0;
    for (int i = 0; i < n; i++) b[i] = l[8*(n-1-i) +: 8];
    di <= {k, 16'(n + p), b, h};
    dv <= 1'b1;
    do @(posedge clk); while (!drdy);
    dv <= 1'b0;
    do @(posedge clk); while (!(dvo || ddrop));
    chk(ddrop, d);
    if (k == thdc_pkg::PACKET_B && !d) begin
      e.tot_len = 16'(p + 40);
      e.ip_sum = ipsum(e);
    end
    if (!d) chk(dq.hdr, e);
    if (!d) chk(dq.pay_off, k == thdc_pkg::PACKET_B ? n : 0);
    drops += int'(d);
  endtask
  // =========
  // Clock, timeout and tests
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    {rst_n, psel, pen, pwr, cv, dv, pa, pwd, ci, di} = '0;
    slow = 1'b1;
    h = '0;
    h.ver_ihl_tos = 16'h4500;
    h.tot_len = 16'h0028;
    h.proto = thdc_pkg::TCP_PROTO;
    h.tcp_off = 4'h5;
    h.tcp_flags = 8'h10;
    h.tcp_sum = 16'hc1c2;
    hb = h;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, thdc_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 12'h00c, 32'h0);
    chk({err, rd}, 33'h100000000);
    apb(1'b1, thdc_pkg::REG_CTRL, 32'h2);
    chk(crdy, 1'b0);
    apb(1'b1, thdc_pkg::REG_CTRL, 32'h3);
    cstep(1'b1, 8'h01, thdc_pkg::PACKET_A, 0, 0);
    h.seq += 10;
    h.ip_id += 1;
    h.tcp_flags = 8'h18;
    cstep(1'b0, 8'h01, thdc_pkg::PACKET_B, 4, 32'h18c1c20a);
    h.win += 16'h1234;
    h.ack += 300;
    h.tot_len = 16'h0032;
    h.tcp_flags = 8'h10;
    cstep(1'b0, 8'h01, thdc_pkg::PACKET_B, 12, 96'h26c1c200123400012c000000);
    h.seq += 10;
    h.ack += 10;
    h.ip_id += 1;
    cstep(1'b0, 8'h01, thdc_pkg::PACKET_B, 3, 24'h0bc1c2);
    h.seq += 10;
    h.ip_id += 1;
    cstep(1'b0, 8'h01, thdc_pkg::PACKET_B, 3, 24'h0fc1c2);
    h.tcp_flags = 8'h30;
    h.ip_id += 1;
    cstep(1'b0, 8'h01, thdc_pkg::PACKET_B, 6, 48'h01c1c2000000);
    h.seq -= 1;
    h.tcp_flags = 8'h10;
    h.ip_id += 1;
    cstep(1'b0, 8'h01, thdc_pkg::PACKET_A, 0, 0);
    h.ip_id += 1;
    cstep(1'b0, 8'h01, thdc_pkg::PACKET_A, 0, 0);
    h.tcp_flags = 8'h30;
    h.urp = 16'h0005;
    h.seq += 1;
    h.win += 1;
    h.ip_id += 1;
    cstep(1'b0, 8'h01, thdc_pkg::PACKET_A, 0, 0);
    cstep(1'b1, 8'h02, thdc_pkg::PACKET_A, 0, 0);
    h.seq += 1;
    h.ip_id += 1;
    cstep(1'b0, 8'h01, thdc_pkg::PACKET_B, 6, 48'h4901c1c20501);
    cstep(1'b0, 8'h02, thdc_pkg::PACKET_PLAIN_IP, 0, 0);
    slow <= 1'b0;
    h = hb;
    e = hb;
    for (int k = 3; k < 8; k++) dstep(k == 3 ? 3'h0 : 3'(k), 0, 0, 0, 1'b1);
    chk(ddisc, 1'b1);
    dstep(thdc_pkg::PACKET_B, 4, 0, 32'h08c1c201, 1'b1);
    h.proto = 8'h10;
    dstep(thdc_pkg::PACKET_A, 0, 0, 0, 1'b1);
    h.proto = 8'h03;
    dstep(thdc_pkg::PACKET_A, 0, 0, 0, 1'b0);
    dstep(thdc_pkg::PACKET_ERROR, 0, 0, 0, 1'b1);
    e.seq += 5;
    e.ip_id += 1;
    e.tcp_sum = 16'habcd;
    dstep(thdc_pkg::PACKET_B, 5, 5, 40'h4803abcd05, 1'b0);
    chk(ddisc, 1'b0);
    e.seq += 5;
    e.ip_id += 1;
    e.tcp_flags = 8'h18;
    dstep(thdc_pkg::PACKET_B, 3, 7, 24'h1fabcd, 1'b0);
    e.seq += 7;
    e.ack += 7;
    e.ip_id += 1;
    e.tcp_flags = 8'h10;
    dstep(thdc_pkg::PACKET_B, 3, 0, 24'h0babcd, 1'b0);
    e.tcp_flags = 8'h30;
    e.urp = 16'h0009;
    e.win -= 16;
    e.ack += 2;
    e.ip_id += 5;
    dstep(thdc_pkg::PACKET_B, 9, 0, 72'h27abcd0900fff00205, 1'b0);
    h = hb;
    e = hb;
    dstep(thdc_pkg::PACKET_PLAIN_IP, 0, 0, 0, 1'b0);
    apb(1'b0, thdc_pkg::REG_STATUS, 32'h0);
    chk(rd[23:0], 24'h030100);
    apb(1'b0, thdc_pkg::REG_COUNT, 32'h0);
    chk(rd, {16'(drops), 16'h0006});
    final_report();
  end
endmodule
bind thdc_codec thdc_checker u_thdc_checker (
  .CLK_SYS_IN(CLK_SYS_IN), .ARST_N_IN(ARST_N_IN), .C_VALID_IN(C_VALID_IN),
  .C_PKT_IN(C_PKT_IN), .C_READY_OUT(C_READY_OUT), .C_VALID_OUT(C_VALID_OUT),
  .C_PKT_OUT(C_PKT_OUT), .D_VALID_IN(D_VALID_IN), .D_PKT_IN(D_PKT_IN),
  .D_READY_OUT(D_READY_OUT), .D_VALID_OUT(D_VALID_OUT), .D_PKT_OUT(D_PKT_OUT),
  .D_DROP_OUT(D_DROP_OUT), .D_DISCARD_OUT(D_DISCARD_OUT));
`default_nettype wire
